// file: pgt_core.sv
// Purpose: timing core of two pulse generators with count registers
// Assumes: register port and config bits come from logic on i_clock
// Notes: generator two delivers only its initial-delay timing
// Function
// - Generator one's 8-bit read/write period count sets its cycle length.
// - The period is that count times the 1 ms or 125 ms period base.
// - Generator one's 8-bit read/write on count sets its active time.
// - The on time is that count times the on base, zero giving no pulse.
// - Generator two's 8-bit read/write delay runs from the first base tick.
// - Generator two's delay is counted in ticks of its own period base.
// - A base select bit low picks 1 ms ticks, high picks 125 ms ticks.
// - A disabled generator drives its inactive level without pause.
// - The invert bit flips generator one's output.
`timescale 1ns/100ps
`default_nettype none
module pgt_core #(
    parameter int FINE_CYCLES = pgt_pkg::FINE_BASE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_pulse_one_enable_bit,
    input wire logic i_pulse_one_invert_bit,
    input wire logic i_pulse_one_period_base_sel,
    input wire logic i_pulse_one_on_base_sel,
    input wire logic i_pulse_two_enable_bit,
    input wire logic i_pulse_two_period_base_sel,
    output logic o_pulse_one_out,
    output logic o_pulse_two_delay_done
);
    typedef struct packed {
        logic [7:0] period_count;
        logic [7:0] on_count;
        logic [7:0] start_delay;
        logic [7:0] rdata;
        pgt_pkg::pgt_g1_state_t g1;
        logic [7:0] pcnt;
        logic [7:0] ocnt;
        logic active;
        logic out;
        pgt_pkg::pgt_g2_state_t g2;
        logic [7:0] dcnt;
        logic done;
    } pgt_core_state_t;

    pgt_core_state_t st_reg;
    pgt_core_state_t st_next;
    logic tick_fine;
    logic tick_coarse;
    logic ptick_one;
    logic otick_one;
    logic ptick_two;
    logic [7:0] pcnt_inc;
    logic [7:0] ocnt_inc;
    logic [7:0] dcnt_inc;
    logic period_wrap;
    logic cycle_opens_on;

    pgt_timebase #(
        .FINE_CYCLES(FINE_CYCLES)
    ) u_timebase (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .o_tick_fine(tick_fine),
        .o_tick_coarse(tick_coarse)
    );

    // the 125 ms tick lands on a 1 ms tick, so a 125 ms period with a 1 ms on base stays aligned
    assign ptick_one = i_pulse_one_period_base_sel ? tick_coarse :
        tick_fine;
    assign otick_one = i_pulse_one_on_base_sel ? tick_coarse :
        tick_fine;
    assign ptick_two = i_pulse_two_period_base_sel ? tick_coarse :
        tick_fine;
    assign pcnt_inc = st_reg.pcnt + 8'h01;
    assign ocnt_inc = st_reg.ocnt + 8'h01;
    assign dcnt_inc = st_reg.dcnt + 8'h01;
    // greater-or-equal so a count lowered mid-cycle cannot run past 255
    assign period_wrap = pcnt_inc >= st_reg.period_count;
    assign cycle_opens_on = (st_reg.on_count != 8'h00) &&
        (st_reg.period_count != 8'h00);

    always_comb begin
        st_next = st_reg;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                pgt_pkg::ADDR_PULSE_ONE_PERIOD: begin
                    st_next.period_count = i_reg_wdata;
                end
                pgt_pkg::ADDR_PULSE_ONE_ON: begin
                    st_next.on_count = i_reg_wdata;
                end
                pgt_pkg::ADDR_PULSE_TWO_DELAY: begin
                    st_next.start_delay = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
        unique case (i_reg_addr)
            pgt_pkg::ADDR_PULSE_ONE_PERIOD: begin
                st_next.rdata = st_reg.period_count;
            end
            pgt_pkg::ADDR_PULSE_ONE_ON: begin
                st_next.rdata = st_reg.on_count;
            end
            pgt_pkg::ADDR_PULSE_TWO_DELAY: begin
                st_next.rdata = st_reg.start_delay;
            end
            default: begin
                st_next.rdata = pgt_pkg::RDATA_UNMAPPED;
            end
        endcase

        unique case (st_reg.g1)
            pgt_pkg::PGT_G1_IDLE: begin
                if (i_pulse_one_enable_bit) begin
                    st_next.g1 = pgt_pkg::PGT_G1_WAIT;
                end
            end
            pgt_pkg::PGT_G1_WAIT: begin
                if (ptick_one) begin
                    st_next.g1 = pgt_pkg::PGT_G1_RUN;
                    st_next.pcnt = 8'h00;
                    st_next.ocnt = 8'h00;
                    st_next.active = cycle_opens_on;
                end
            end
            pgt_pkg::PGT_G1_RUN: begin
                if (ptick_one && period_wrap) begin
                    st_next.pcnt = 8'h00;
                    st_next.ocnt = 8'h00;
                    st_next.active = cycle_opens_on;
                end else begin
                    if (ptick_one) begin
                        st_next.pcnt = pcnt_inc;
                    end
                    if (otick_one && st_reg.active) begin
                        st_next.ocnt = ocnt_inc;
                        if (ocnt_inc >= st_reg.on_count) begin
                            st_next.active = 1'b0;
                        end
                    end
                end
            end
            default: begin
                st_next.g1 = pgt_pkg::PGT_G1_IDLE;
            end
        endcase
        if (!i_pulse_one_enable_bit) begin
            st_next.g1 = pgt_pkg::PGT_G1_IDLE;
            st_next.active = 1'b0;
        end
        st_next.out = st_next.active ^ i_pulse_one_invert_bit;

        unique case (st_reg.g2)
            pgt_pkg::PGT_G2_IDLE: begin
                if (i_pulse_two_enable_bit) begin
                    st_next.g2 = pgt_pkg::PGT_G2_WAIT;
                end
            end
            pgt_pkg::PGT_G2_WAIT: begin
                if (ptick_two) begin
                    st_next.dcnt = 8'h00;
                    if (st_reg.start_delay == 8'h00) begin
                        st_next.g2 = pgt_pkg::PGT_G2_DONE;
                        st_next.done = 1'b1;
                    end else begin
                        st_next.g2 = pgt_pkg::PGT_G2_DELAY;
                    end
                end
            end
            pgt_pkg::PGT_G2_DELAY: begin
                if (ptick_two) begin
                    st_next.dcnt = dcnt_inc;
                    if (dcnt_inc >= st_reg.start_delay) begin
                        st_next.g2 = pgt_pkg::PGT_G2_DONE;
                        st_next.done = 1'b1;
                    end
                end
            end
            pgt_pkg::PGT_G2_DONE: begin
            end
        endcase
        if (!i_pulse_two_enable_bit) begin
            st_next.g2 = pgt_pkg::PGT_G2_IDLE;
            st_next.done = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_reg_rdata = st_reg.rdata;
    assign o_pulse_one_out = st_reg.out;
    assign o_pulse_two_delay_done = st_reg.done;

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    sequence s_period_write;
        i_reg_wr && i_reg_addr == pgt_pkg::ADDR_PULSE_ONE_PERIOD;
    endsequence
    sequence s_cycle_wrap;
        st_reg.g1 == pgt_pkg::PGT_G1_RUN && ptick_one && period_wrap &&
            i_pulse_one_enable_bit;
    endsequence
    sequence s_on_expiry;
        st_reg.g1 == pgt_pkg::PGT_G1_RUN && st_reg.active && otick_one &&
            ocnt_inc >= st_reg.on_count && !(ptick_one && period_wrap);
    endsequence

    period_write_read_a: assert property (
        s_period_write ##1 i_reg_addr == pgt_pkg::ADDR_PULSE_ONE_PERIOD
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("period count not read back");
    on_write_store_a: assert property (
        i_reg_wr && i_reg_addr == pgt_pkg::ADDR_PULSE_ONE_ON
        |=> st_reg.on_count == $past(i_reg_wdata))
        else $error("on count not stored");
    cycle_restart_a: assert property (
        s_cycle_wrap ##0 cycle_opens_on
        |=> st_reg.active && st_reg.pcnt == 8'h00)
        else $error("cycle did not restart active");
    on_expiry_a: assert property (
        s_on_expiry ##0 i_pulse_one_enable_bit |=> !st_reg.active)
        else $error("active level outlived on time");
    zero_on_idle_a: assert property (
        st_reg.on_count == 8'h00 && !st_reg.active |=> !st_reg.active)
        else $error("active with zero on count");
    active_fall_cause_a: assert property (
        $fell(st_reg.active) |-> $past(otick_one || ptick_one ||
            !i_pulse_one_enable_bit))
        else $error("active ended without a tick");
    disabled_level_a: assert property (
        !i_pulse_one_enable_bit [*2]
        |-> o_pulse_one_out == $past(i_pulse_one_invert_bit))
        else $error("disabled output not inactive");
    out_polarity_a: assert property (
        ##1 o_pulse_one_out ==
            (st_reg.active ^ $past(i_pulse_one_invert_bit)))
        else $error("output polarity wrong");
    delay_on_tick_a: assert property (
        $rose(o_pulse_two_delay_done) |-> $past(ptick_two))
        else $error("delay ended off a base tick");
    delay_count_a: assert property (
        st_reg.g2 == pgt_pkg::PGT_G2_DELAY && ptick_two &&
            dcnt_inc >= st_reg.start_delay && i_pulse_two_enable_bit
        |=> o_pulse_two_delay_done)
        else $error("delay not ended at count");
endmodule
`default_nettype wire

// file: pgt_pkg.sv
// Purpose: shared constants and types of the pulse generator timing core
// Assumes: 200 MHz core clock
// Notes: register offsets are byte addresses on the device register port
package pgt_pkg;
    localparam logic [7:0] ADDR_PULSE_ONE_PERIOD = 8'h30;
    localparam logic [7:0] ADDR_PULSE_ONE_ON = 8'h31;
    localparam logic [7:0] ADDR_PULSE_TWO_DELAY = 8'h32;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    localparam int CLOCK_PERIOD_NS = 5;
    localparam int FINE_BASE_TIME_NS = 1000000;
    localparam int FINE_BASE_TIME_MS = 1;
    localparam int COARSE_BASE_TIME_MS = 125;
    localparam int FINE_BASE_CYCLES = FINE_BASE_TIME_NS / CLOCK_PERIOD_NS;
    localparam int FINE_PER_COARSE = COARSE_BASE_TIME_MS / FINE_BASE_TIME_MS;
    localparam int TB_CYCLE_W = 18;
    localparam int TB_FINE_W = 7;

    typedef enum logic [1:0] {
        PGT_G1_IDLE = 2'b00,
        PGT_G1_WAIT = 2'b01,
        PGT_G1_RUN = 2'b10
    } pgt_g1_state_t;

    typedef enum logic [1:0] {
        PGT_G2_IDLE = 2'b00,
        PGT_G2_WAIT = 2'b01,
        PGT_G2_DELAY = 2'b10,
        PGT_G2_DONE = 2'b11
    } pgt_g2_state_t;
endpackage

// file: pgt_timebase.sv
// Purpose: free-running 1 ms and 125 ms tick generator
// Assumes: FINE_CYCLES core clocks per 1 ms tick, at most 2**18
// Notes: every 125 ms tick coincides with a 1 ms tick
`timescale 1ns/100ps
`default_nettype none
module pgt_timebase #(
    parameter int FINE_CYCLES = pgt_pkg::FINE_BASE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    output logic o_tick_fine,
    output logic o_tick_coarse
);
    localparam int CYC_W = pgt_pkg::TB_CYCLE_W;
    localparam int FINE_W = pgt_pkg::TB_FINE_W;
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(FINE_CYCLES - 1);
    localparam logic [FINE_W-1:0] FINE_LAST =
        FINE_W'(pgt_pkg::FINE_PER_COARSE - 1);

    typedef struct packed {
        logic [pgt_pkg::TB_CYCLE_W-1:0] cyc;
        logic [pgt_pkg::TB_FINE_W-1:0] fine;
        logic tick_fine;
        logic tick_coarse;
    } pgt_tb_state_t;

    pgt_tb_state_t st_reg;
    pgt_tb_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick_fine = 1'b0;
        st_next.tick_coarse = 1'b0;
        if (st_reg.cyc >= CYC_LAST) begin
            st_next.cyc = '0;
            st_next.tick_fine = 1'b1;
            if (st_reg.fine >= FINE_LAST) begin
                st_next.fine = '0;
                st_next.tick_coarse = 1'b1;
            end else begin
                st_next.fine = st_reg.fine + 7'h01;
            end
        end else begin
            st_next.cyc = st_reg.cyc + 18'h00001;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_tick_fine = st_reg.tick_fine;
    assign o_tick_coarse = st_reg.tick_coarse;

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    coarse_on_fine_a: assert property (
        o_tick_coarse |-> o_tick_fine)
        else $error("coarse tick without fine tick");
endmodule
`default_nettype wire

// file: tb_pulse_generator_timing.sv
// Purpose: self-checking bench of the pulse generator timing core
// Assumes: FINE_CYCLES cut to 4, so one 125 ms tick spans 500 clocks
// Notes: drivers queue expected results, a monitor pops and compares them
`timescale 1ns/100ps
`default_nettype none
module tb_pulse_generator_timing;
    localparam int F = 4;
    localparam int C = F * pgt_pkg::FINE_PER_COARSE;
    typedef struct {
        logic kind;
        logic lvl;
        logic [1:0] sel;
        logic [31:0] val;
        string nm;
    } pgt_exp_t;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0, en1 = 1'b0, inv = 1'b0, pb1 = 1'b0, ob1 = 1'b0;
    logic en2 = 1'b0, pb2 = 1'b0, out1, done2;
    logic [7:0] rdata;
    logic tgl = 1'b0, tgl_last = 1'b0, seen = 1'b0;
    logic arm = 1'b0, started = 1'b0, prev = 1'b0;
    logic [15:0] lfsr_state = 16'hcc73;
    logic [7:0] ra [4] = '{pgt_pkg::ADDR_PULSE_ONE_PERIOD,
        pgt_pkg::ADDR_PULSE_ONE_ON, pgt_pkg::ADDR_PULSE_TWO_DELAY, 8'h33};
    logic [7:0] v [4];
    int run = 0;
    int error_cnt = 0;
    int n_checks = 0;
    pgt_exp_t q[$];

    always #2.5 i_clock = ~i_clock;

    pgt_core #(.FINE_CYCLES(F)) DUT (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_reg_addr(addr),
        .i_reg_wr(wr),
        .i_reg_wdata(wdata),
        .o_reg_rdata(rdata),
        .i_pulse_one_enable_bit(en1),
        .i_pulse_one_invert_bit(inv),
        .i_pulse_one_period_base_sel(pb1),
        .i_pulse_one_on_base_sel(ob1),
        .i_pulse_two_enable_bit(en2),
        .i_pulse_two_period_base_sel(pb2),
        .o_pulse_one_out(out1),
        .o_pulse_two_delay_done(done2)
    );

    function automatic logic [7:0] rnd();
        lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13]
            ^ lfsr_state[12] ^ lfsr_state[10]};
        return lfsr_state[7:0];
    endfunction

    task automatic check(input string nm, input logic [31:0] s,
            input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    // a toggle marks each sample request, so back-to-back requests work
    always @(posedge i_clock) begin
        pgt_exp_t e;
        if (seen && q.size() > 0 && q[0].kind == 1'b0) begin
            e = q.pop_front();
            case (e.sel)
                2'd0: check(e.nm, {24'h0, rdata}, e.val);
                2'd1: check(e.nm, {31'h0, out1}, e.val);
                default: check(e.nm, {31'h0, done2}, e.val);
            endcase
        end
        seen <= (tgl != tgl_last);
        tgl_last <= tgl;
        // the first run after arming is partial and is thrown away
        if (out1 !== prev) begin
            if (started && q.size() > 0 && q[0].kind &&
                    q[0].lvl === prev) begin
                e = q.pop_front();
                check(e.nm, 32'(run), e.val);
            end
            started <= arm;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        prev <= out1;
    end

    task automatic samp(input logic [1:0] sel, input logic [7:0] a,
            input logic [31:0] x, input string nm);
        addr = a;
        tgl = ~tgl;
        q.push_back('{1'b0, 1'b0, sel, x, nm});
        @(negedge i_clock);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clock);
        wr = 1'b0;
        @(negedge i_clock);
    endtask

    task automatic drain(input int n);
        while (q.size() > 0 && n > 0) begin
            n--;
            @(negedge i_clock);
        end
        check("queue left", q.size(), 32'h0);
        q.delete();
    endtask

    task automatic gen1(input logic pb, ob, iv, input logic [7:0] p, o);
        int pc;
        int oc;
        pc = pb ? C : F;
        oc = ob ? C : F;
        en1 = 1'b0;
        inv = iv;
        pb1 = pb;
        ob1 = ob;
        wreg(ra[0], p);
        wreg(ra[1], o);
        q.push_back('{1'b1, ~iv, 2'd0, o * oc, "on run"});
        q.push_back('{1'b1, iv, 2'd0, p * pc - o * oc, "off run"});
        arm = 1'b1;
        en1 = 1'b1;
        drain(3 * p * pc + 20);
        arm = 1'b0;
        $display("waveform case p=%0d o=%0d done", p, o);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge i_clock);
        i_rstn = 1'b1;
        @(negedge i_clock);
        for (int i = 0; i < 4; i++) begin
            samp(2'd0, ra[i], pgt_pkg::COUNT_RESET, "reset value");
        end
        // the unmapped write goes last so a loose decode would clobber one
        for (int i = 0; i < 4; i++) begin
            v[i] = rnd();
            wreg(ra[i], v[i]);
        end
        for (int i = 0; i < 4; i++) begin
            samp(2'd0, ra[i], i < 3 ? v[i] : 8'h00, "read back");
        end
        drain(10);
        $display("register test done");
        // no case pairs a 125 ms on base with a 1 ms period base
        gen1(1'b0, 1'b0, 1'b0, 8'h03, 8'h01);
        gen1(1'b0, 1'b0, 1'b1, 8'h05, 8'h02);
        gen1(1'b1, 1'b0, 1'b0, 8'h01, 8'h03);
        gen1(1'b1, 1'b1, 1'b0, 8'h02, 8'h01);
        gen1(1'b0, 1'b0, 1'b0, 8'hff, 8'hfe);
        for (int k = 0; k < 2; k++) begin
            en1 = 1'b0;
            inv = ~k[0];
            wreg(ra[1], k[0] ? 8'h05 : 8'h00);
            wreg(ra[0], 8'h03);
            en1 = 1'b1;
            repeat (4) begin
                repeat (7) @(negedge i_clock);
                samp(2'd1, 8'h00, 32'h1, "flat level");
            end
        end
        en1 = 1'b0;
        for (int k = 0; k < 2; k++) begin
            inv = k[0];
            repeat (2) @(negedge i_clock);
            samp(2'd1, 8'h00, {31'h0, k[0]}, "idle level");
        end
        drain(10);
        $display("level test done");
        // a coarse tick is a fine tick too, so generator one's first rise
        // marks a tick of generator two's base; k 0 runs them on unlike
        // bases so a swapped base select shows up
        for (int k = 0; k < 3; k++) begin
            int b;
            int d;
            int w;
            b = k == 2 ? C : F;
            d = k == 0 ? 0 : (k == 1 ? 3 : 1);
            en1 = 1'b0;
            inv = 1'b0;
            ob1 = 1'b0;
            pb1 = k != 1;
            pb2 = k == 2;
            wreg(ra[2], d[7:0]);
            wreg(ra[0], 8'hff);
            wreg(ra[1], 8'h01);
            en1 = 1'b1;
            w = 0;
            while (out1 !== 1'b1 && w < 2 * C) begin
                w++;
                @(negedge i_clock);
            end
            en2 = 1'b1;
            repeat ((d + 1) * b - 2) @(negedge i_clock);
            samp(2'd2, 8'h00, 32'h0, "delay wait");
            samp(2'd2, 8'h00, 32'h1, "delay end");
            en2 = 1'b0;
            @(negedge i_clock);
            samp(2'd2, 8'h00, 32'h0, "delay clear");
            drain(10);
        end
        $display("delay test done");
        end_of_test();
    end

    initial begin
        repeat (40000) @(posedge i_clock);
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
